// ==== slam_top.sv ====
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module slam_top (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [7:0]  LANE_FIFO_ERR,
  input  wire logic        SER_PLL_LOCK,
  input  wire logic        SYSREF,
  input  wire logic        NCO_UPSET,
  input  wire logic        CLK_PHASE_A,
  input  wire logic        CLK_PHASE_B,
  input  wire logic        SYNC_N,
  input  wire logic        POWER_DOWN_PIN,
  input  wire logic        CAL_BUSY,
  output logic             LINK_RESET,
  output logic             SER_POWER_DOWN,
  output logic             LINK_CLK_EN,
  output logic             SER_REINIT,
  output logic [3:0]       SER_EMPHASIS,
  output logic             CH_A_POWER_DOWN,
  output logic             CH_B_POWER_DOWN,
  output logic             LOCAL_MULTIFRAME_CLOCK,
  output logic             LOCAL_EXTENDED_MULTIBLOCK_CLOCK,
  output logic [3:0]       LINK_STATE,
  output logic             CAL_STATUS_PIN
);

  typedef struct packed {
    logic                aw_held;
    logic [7:0]          aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [31:0]         ctrl;
    logic [5:0]          flags;
    logic [5:0]          mask;
    logic [7:0]          lanes;
    logic                summary;
    logic                pin;
    slam_pkg::slam_link_e link;
    logic [4:0]          mf_cnt;
    logic                mf_pulse;
    logic [2:0]          ilas_cnt;
    logic [4:0]          reinit_cnt;
    logic                sysref_prev;
    logic                pwrdn_prev;
  } slam_top_state_s;

  slam_top_state_s s_q;
  slam_top_state_s s_d;
  logic [15:0]     si;
  logic [31:0]     wd;
  logic            wr_fire;
  logic [5:0]      clr_flags;
  logic [7:0]      clr_lanes;
  logic [5:0]      ev;
  logic [7:0]      lane_ev;
  logic            en;
  logic            sysref_rise;
  logic            clk_mis;
  logic            code64;
  logic            mf_wrap;
  logic [5:0]      keep_v;
  logic [5:0]      unm;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  slam_sync #(
    .W (slam_pkg::SYNC_W)
  ) u_sync (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .D       ({CAL_BUSY, POWER_DOWN_PIN, SYNC_N, CLK_PHASE_B,
               CLK_PHASE_A, NCO_UPSET, SYSREF, SER_PLL_LOCK,
               LANE_FIFO_ERR}),
    .Q       (si)
  );

  // ***********************************************************
  // Event decode
  // ***********************************************************
  assign wr_fire   = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign wd        = s_q.w_data & strb_mask(s_q.w_strb);
  assign clr_flags = (wr_fire && s_q.aw_addr == slam_pkg::OFF_FLAGS) ?
                     wd[5:0] : 6'h00;
  assign clr_lanes = (wr_fire && s_q.aw_addr == slam_pkg::OFF_LANES) ?
                     wd[7:0] : 8'h00;
  // Power-down pin and reinit also hold the link off
  assign en = s_q.ctrl[slam_pkg::CTRL_EN_BIT] && !si[slam_pkg::SI_PWRDN] &&
              s_q.reinit_cnt == 5'h00;
  assign code64      = s_q.ctrl[slam_pkg::CTRL_CODE64_BIT];
  assign sysref_rise = si[slam_pkg::SI_SYSREF] && !s_q.sysref_prev &&
                       s_q.ctrl[slam_pkg::CTRL_SUBCLASS_BIT];
  assign mf_wrap     = s_q.mf_cnt == slam_pkg::MF_LAST;
  // Only meaningful with both channels running
  assign clk_mis = !s_q.ctrl[slam_pkg::CTRL_PDA_BIT] &&
                   !s_q.ctrl[slam_pkg::CTRL_PDB_BIT] &&
                   (si[slam_pkg::SI_CLKA] != si[slam_pkg::SI_CLKB]);
  assign lane_ev = (s_q.link != slam_pkg::LS_OFF) ?
                   si[slam_pkg::SI_LANE_LSB +: 8] : 8'h00;

  always_comb begin
    ev                       = 6'h00;
    ev[slam_pkg::ALM_FIFO]   = |lane_ev;
    ev[slam_pkg::ALM_PLL]    = en && !si[slam_pkg::SI_PLL];
    ev[slam_pkg::ALM_NODATA] = s_q.ctrl[slam_pkg::CTRL_EN_BIT] &&
                               s_q.link != slam_pkg::LS_DATA;
    ev[slam_pkg::ALM_SYSREF] = sysref_rise &&
                               s_q.link != slam_pkg::LS_OFF &&
                               s_q.mf_cnt != 5'h00;
    ev[slam_pkg::ALM_NCO]    = si[slam_pkg::SI_NCO];
    // Leaving power-down disturbs the channel clocks
    ev[slam_pkg::ALM_CLK]    = clk_mis || (s_q.pwrdn_prev &&
                               !si[slam_pkg::SI_PWRDN]);
  end

  assign keep_v = s_q.flags & ~clr_flags;
  assign unm    = s_q.flags & ~s_q.mask;

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    s_d             = s_q;
    s_d.sysref_prev = si[slam_pkg::SI_SYSREF];
    s_d.pwrdn_prev  = si[slam_pkg::SI_PWRDN];

    // Bus slave: address and data taken in either order
    if (S_AXI_AWVALID && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.w_data = S_AXI_WDATA;
      s_d.w_strb = S_AXI_WSTRB;
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = slam_pkg::RESP_OKAY;
      if (s_q.aw_addr == slam_pkg::OFF_CTRL) begin
        s_d.ctrl = ((s_q.ctrl & ~strb_mask(s_q.w_strb)) | wd) &
                   slam_pkg::CTRL_WMASK;
      end else if (s_q.aw_addr == slam_pkg::OFF_MASK) begin
        if (s_q.w_strb[0]) begin
          s_d.mask = s_q.w_data[5:0];
        end
      end else if (s_q.aw_addr == slam_pkg::OFF_FLAGS ||
                   s_q.aw_addr == slam_pkg::OFF_LANES ||
                   s_q.aw_addr == slam_pkg::OFF_SUMMARY ||
                   s_q.aw_addr == slam_pkg::OFF_STATUS) begin
        s_d.bresp = slam_pkg::RESP_OKAY;
      end else begin
        s_d.bresp = slam_pkg::RESP_SLVERR;
      end
    end

    if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = slam_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (S_AXI_ARADDR == slam_pkg::OFF_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (S_AXI_ARADDR == slam_pkg::OFF_FLAGS) begin
        s_d.rdata[5:0] = s_q.flags;
      end else if (S_AXI_ARADDR == slam_pkg::OFF_MASK) begin
        s_d.rdata[5:0] = s_q.mask;
      end else if (S_AXI_ARADDR == slam_pkg::OFF_SUMMARY) begin
        s_d.rdata[0] = s_q.summary;
      end else if (S_AXI_ARADDR == slam_pkg::OFF_LANES) begin
        s_d.rdata[7:0] = s_q.lanes;
      end else if (S_AXI_ARADDR == slam_pkg::OFF_STATUS) begin
        s_d.rdata[3:0]  = s_q.link;
        s_d.rdata[12:8] = s_q.mf_cnt;
      end else begin
        s_d.rresp = slam_pkg::RESP_SLVERR;
      end
    end

    // Set wins over a coincident clear
    s_d.flags   = keep_v | ev;
    s_d.lanes   = (s_q.lanes & ~clr_lanes) | lane_ev;
    s_d.summary = |unm;
    s_d.pin     = s_q.ctrl[slam_pkg::CTRL_PINSEL_BIT] ?
                  s_q.summary : si[slam_pkg::SI_CAL];

    // Reinit holds the link off for a fixed stretch
    if (s_q.reinit_cnt != 5'h00) begin
      s_d.reinit_cnt = s_q.reinit_cnt - 5'h01;
    end else if (ev[slam_pkg::ALM_FIFO] &&
                 s_q.ctrl[slam_pkg::CTRL_REINIT_BIT]) begin
      s_d.reinit_cnt = slam_pkg::REINIT_CYCLES;
    end

    // Multiframe clock: free running while enabled unless SYSREF realigns it
    s_d.mf_cnt   = s_q.mf_cnt + 5'h01;
    s_d.mf_pulse = mf_wrap;
    if (sysref_rise) begin
      s_d.mf_cnt   = 5'h00;
      s_d.mf_pulse = 1'b1;
    end

    case (s_q.link)
      slam_pkg::LS_OFF: begin
        s_d.link = slam_pkg::LS_CGS;
      end
      slam_pkg::LS_CGS: begin
        s_d.ilas_cnt = 3'h0;
        if (mf_wrap && (code64 || si[slam_pkg::SI_SYNC])) begin
          s_d.link = code64 ? slam_pkg::LS_DATA :
                              slam_pkg::LS_ILAS;
        end
      end
      slam_pkg::LS_ILAS: begin
        if (!si[slam_pkg::SI_SYNC]) begin
          s_d.link = slam_pkg::LS_CGS;
        end else if (mf_wrap) begin
          s_d.ilas_cnt = s_q.ilas_cnt + 3'h1;
          if (s_q.ilas_cnt == slam_pkg::ILAS_MF_LAST) begin
            s_d.link = slam_pkg::LS_DATA;
          end
        end
      end
      slam_pkg::LS_DATA: begin
        if (!code64 && !si[slam_pkg::SI_SYNC]) begin
          s_d.link = slam_pkg::LS_CGS;
        end
      end
      default: begin
        s_d.link = slam_pkg::LS_OFF;
      end
    endcase

    // Reinit drops the link at once, not a cycle after the counter
    if (s_d.reinit_cnt != 5'h00) begin
      s_d.link = slam_pkg::LS_OFF;
    end

    // Disabled link: reset, clocks stopped, counter parked
    if (!en) begin
      s_d.link     = slam_pkg::LS_OFF;
      s_d.mf_cnt   = 5'h00;
      s_d.mf_pulse = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_q      <= '0;
      s_q.ctrl <= slam_pkg::CTRL_RESET;
      s_q.mask <= slam_pkg::MASK_RESET;
      s_q.link <= slam_pkg::LS_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign S_AXI_AWREADY   = !s_q.aw_held;
  assign S_AXI_WREADY    = !s_q.w_held;
  assign S_AXI_BVALID    = s_q.bvalid;
  assign S_AXI_BRESP     = s_q.bresp;
  assign S_AXI_ARREADY   = !s_q.rvalid;
  assign S_AXI_RVALID    = s_q.rvalid;
  assign S_AXI_RDATA     = s_q.rdata;
  assign S_AXI_RRESP     = s_q.rresp;
  assign LINK_RESET      = s_q.link == slam_pkg::LS_OFF;
  assign SER_POWER_DOWN  = s_q.link == slam_pkg::LS_OFF;
  assign LINK_CLK_EN     = s_q.link != slam_pkg::LS_OFF;
  assign SER_REINIT      = s_q.reinit_cnt != 5'h00;
  assign SER_EMPHASIS    = s_q.ctrl[slam_pkg::CTRL_EMPH_LSB +:
                                    slam_pkg::EMPH_W];
  assign CH_A_POWER_DOWN = s_q.ctrl[slam_pkg::CTRL_PDA_BIT];
  assign CH_B_POWER_DOWN = s_q.ctrl[slam_pkg::CTRL_PDB_BIT];
  assign LOCAL_MULTIFRAME_CLOCK          = s_q.mf_pulse && !code64;
  assign LOCAL_EXTENDED_MULTIBLOCK_CLOCK = s_q.mf_pulse && code64;
  assign LINK_STATE      = s_q.link;
  assign CAL_STATUS_PIN  = s_q.pin;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_disabled_off: assert property (
    !s_q.ctrl[slam_pkg::CTRL_EN_BIT] |=> LINK_RESET && !LINK_CLK_EN)
    else $error("link not held off while disabled");

  a_sysref_align: assert property (
    sysref_rise && en |=> s_q.mf_cnt == 5'h00 &&
    (LOCAL_MULTIFRAME_CLOCK ^ LOCAL_EXTENDED_MULTIBLOCK_CLOCK))
    else $error("sysref did not realign multiframe clock");

  a_mf_freerun: assert property (
    en && !sysref_rise && s_q.link != slam_pkg::LS_OFF
    |=> s_q.mf_cnt == $past(s_q.mf_cnt) + 5'h01)
    else $error("multiframe counter did not advance");

  a_cgs_no_data: assert property (
    s_q.link == slam_pkg::LS_CGS && !code64 |=> s_q.link != slam_pkg::LS_DATA)
    else $error("data entered without alignment sequence");

  a_flag_sticky: assert property (
    1'b1 |=> (s_q.flags & $past(keep_v)) == $past(keep_v))
    else $error("alarm flag lost without clear");

  a_event_wins: assert property (
    ev != 6'h00 |=> (s_q.flags & $past(ev)) == $past(ev))
    else $error("alarm event lost");

  a_summary_or: assert property (
    1'b1 |=> s_q.summary == (|$past(unm)))
    else $error("summary mismatch");

  a_pin_alarm: assert property (
    s_q.ctrl[slam_pkg::CTRL_PINSEL_BIT] && s_q.summary |=> CAL_STATUS_PIN)
    else $error("status pin not showing alarm");

  a_clk_upset: assert property (
    clk_mis |=> s_q.flags[slam_pkg::ALM_CLK])
    else $error("clock mismatch not flagged");

  a_lane_fifo: assert property (
    lane_ev != 8'h00 |=> s_q.flags[slam_pkg::ALM_FIFO] &&
    (s_q.lanes & $past(lane_ev)) == $past(lane_ev))
    else $error("lane fifo upset not flagged");

  a_reinit_hold: assert property (
    ev[slam_pkg::ALM_FIFO] && s_q.ctrl[slam_pkg::CTRL_REINIT_BIT] &&
    s_q.reinit_cnt == 5'h00 |=> (SER_REINIT && !LINK_CLK_EN)[*8])
    else $error("reinit not held");

  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");

  c_reach_data: cover property (s_q.link == slam_pkg::LS_DATA);
  c_clk_flag: cover property (s_q.flags[slam_pkg::ALM_CLK] && S_AXI_BVALID);
  c_reinit: cover property (SER_REINIT);
  c_slverr: cover property (S_AXI_RVALID &&
                            S_AXI_RRESP == slam_pkg::RESP_SLVERR);

endmodule

// ==== slam_pkg.sv ====
package slam_pkg;

  // ***********************************************************
  // Register map
  // ***********************************************************
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_FLAGS   = 8'h04;
  localparam logic [7:0]  OFF_MASK    = 8'h08;
  localparam logic [7:0]  OFF_SUMMARY = 8'h0c;
  localparam logic [7:0]  OFF_LANES   = 8'h10;
  localparam logic [7:0]  OFF_STATUS  = 8'h14;

  // ***********************************************************
  // Control fields
  // ***********************************************************
  localparam int unsigned CTRL_EN_BIT       = 0;
  localparam int unsigned CTRL_REINIT_BIT   = 1;
  localparam int unsigned CTRL_PINSEL_BIT   = 2;
  localparam int unsigned CTRL_PDA_BIT      = 3;
  localparam int unsigned CTRL_PDB_BIT      = 4;
  localparam int unsigned CTRL_SUBCLASS_BIT = 5;
  localparam int unsigned CTRL_CODE64_BIT   = 6;
  localparam int unsigned CTRL_EMPH_LSB     = 8;
  localparam int unsigned EMPH_W            = 4;
  localparam logic [31:0] CTRL_WMASK        = 32'h0000_0f7f;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

  // ***********************************************************
  // Alarm flags
  // ***********************************************************
  localparam int unsigned NUM_ALARMS = 6;
  localparam int unsigned NUM_LANES  = 8;
  localparam int unsigned ALM_FIFO   = 0;
  localparam int unsigned ALM_PLL    = 1;
  localparam int unsigned ALM_NODATA = 2;
  localparam int unsigned ALM_SYSREF = 3;
  localparam int unsigned ALM_NCO    = 4;
  localparam int unsigned ALM_CLK    = 5;
  localparam logic [5:0]  MASK_RESET = 6'h00;

  // ***********************************************************
  // Timing counts, in CLK cycles (ILAS_MF_LAST in multiframes)
  // ***********************************************************
  localparam int unsigned MF_W          = 5;
  localparam logic [4:0]  MF_LAST       = 5'h1f;
  localparam logic [2:0]  ILAS_MF_LAST  = 3'h3;
  localparam logic [4:0]  REINIT_CYCLES = 5'h10;

  // ***********************************************************
  // Synchronised input bundle
  // ***********************************************************
  localparam int unsigned SI_LANE_LSB = 0;
  localparam int unsigned SI_PLL      = 8;
  localparam int unsigned SI_SYSREF   = 9;
  localparam int unsigned SI_NCO      = 10;
  localparam int unsigned SI_CLKA     = 11;
  localparam int unsigned SI_CLKB     = 12;
  localparam int unsigned SI_SYNC     = 13;
  localparam int unsigned SI_PWRDN    = 14;
  localparam int unsigned SI_CAL      = 15;
  localparam int unsigned SYNC_W      = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    LS_OFF  = 4'b0001,
    LS_CGS  = 4'b0010,
    LS_ILAS = 4'b0100,
    LS_DATA = 4'b1000
  } slam_link_e;

endpackage

// ==== slam_sync.sv ====
`timescale 1ns/1ps
module slam_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         CLK,
  input  wire logic         SYS_RST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } slam_sync_s;

  slam_sync_s s_q;
  slam_sync_s s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d    = s_q;
    s_d.s1 = D;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign Q = s_q.s2;

endmodule

// ==== slam_rx_model.sv ====
`timescale 1ns/1ps
// ******************
// Receiver side model
// ******************
module slam_rx_model #(
  parameter logic [3:0] REL_DELAY = 4'h2
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic [3:0] LINK_STATE,
  input  wire logic       MF_EDGE,
  output logic            SYNC_N,
  output logic            RELEASE
);
  logic [3:0] cgs_q;
  logic [3:0] dly_q;
  logic       arm_q;
  // Holds sync request until code groups have been seen a while
  assign SYNC_N = cgs_q > 4'h7;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cgs_q   <= 4'h0;
      dly_q   <= 4'h0;
      arm_q   <= 1'b0;
      RELEASE <= 1'b0;
    end else begin
      if (LINK_STATE == 4'h1) begin
        cgs_q <= 4'h0;
      end else if (cgs_q != 4'hf) begin
        cgs_q <= cgs_q + 4'h1;
      end
      if (MF_EDGE) begin
        arm_q <= 1'b1;
        dly_q <= 4'h0;
      end else if (arm_q) begin
        dly_q <= dly_q + 4'h1;
      end
      // Release only once the link is in data, REL_DELAY+1 cycles after a multiframe edge is sampled
      RELEASE <= arm_q && dly_q == REL_DELAY && LINK_STATE == 4'h8;
    end
  end
endmodule

// ==== test_serial_link_alarm_monitor.sv ====
`timescale 1ns/1ps
module test_serial_link_alarm_monitor;
  // ******************
  // Signals
  // ******************
  logic        CLK, SYS_RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic        S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic        S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, SER_PLL_LOCK;
  logic        SYSREF, NCO_UPSET, CLK_PHASE_A, CLK_PHASE_B, SYNC_N;
  logic        POWER_DOWN_PIN, CAL_BUSY, LINK_RESET, SER_POWER_DOWN;
  logic        LINK_CLK_EN, SER_REINIT, CH_A_POWER_DOWN, CH_B_POWER_DOWN;
  logic        LOCAL_MULTIFRAME_CLOCK, LOCAL_EXTENDED_MULTIBLOCK_CLOCK;
  logic        CAL_STATUS_PIN, rel;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, LANE_FIFO_ERR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [3:0]  S_AXI_WSTRB, SER_EMPHASIS, LINK_STATE;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  int          fail_count, tests_run, cyc;

  slam_top u_slam_top (.*);
  slam_rx_model u_slam_rx_model (
    .CLK       (CLK),
    .SYS_RST   (SYS_RST),
    .LINK_STATE(LINK_STATE),
    .MF_EDGE   (LOCAL_MULTIFRAME_CLOCK | LOCAL_EXTENDED_MULTIBLOCK_CLOCK),
    .SYNC_N    (SYNC_N),
    .RELEASE   (rel)
  );

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // ******************
  // Helpers
  // ******************
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    // Whole run needs well under a thousand cycles
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // Readiness judged at the falling edge, so the rising edge decides
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] q);
    logic ad, wd, bd;
    ad = 0;
    wd = 0;
    bd = 0;
    @(posedge CLK);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, v};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    while (!bd) begin
      @(negedge CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) ad = 1;
      if (S_AXI_WVALID && S_AXI_WREADY) wd = 1;
      if (S_AXI_BVALID === 1'b1) {bd, q} = {1'b1, S_AXI_BRESP};
      @(posedge CLK);
      if (ad) S_AXI_AWVALID <= 1'b0;
      if (wd) S_AXI_WVALID <= 1'b0;
      if (bd) S_AXI_BREADY <= 1'b0;
    end
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    while (!dd) begin
      @(negedge CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) ad = 1;
      if (S_AXI_RVALID === 1'b1) {dd, v, q} = {1'b1, S_AXI_RDATA, S_AXI_RRESP};
      @(posedge CLK);
      if (ad) S_AXI_ARVALID <= 1'b0;
      if (dd) S_AXI_RREADY <= 1'b0;
    end
  endtask

  // ******************
  // Scenarios
  // ******************
  task t_reset;
    @(negedge CLK);
    chk("link_reset", 1, LINK_RESET);
    chk("ser_pd", 1, SER_POWER_DOWN);
    chk("clk_en", 0, LINK_CLK_EN);
    rd(8'h00, d, r);
    chk("ctrl", 0, d);
    rd(8'h18, d, r);
    chk("bad_rresp", 2, r);
    wr(8'h18, 32'h1, r);
    chk("bad_bresp", 2, r);
    $display("test reset done");
  endtask

  task t_enable;
    int n, p;
    n = 0;
    p = 0;
    wr(8'h00, 32'h501, r);
    while (LINK_STATE !== 4'h8 && n < 800) begin
      @(negedge CLK);
      p = p + int'(LOCAL_MULTIFRAME_CLOCK === 1'b1);
      n++;
    end
    chk("state", 8, LINK_STATE);
    chk("local_multiframe_clock_free", 1, p > 0);
    chk("clk_en", 1, LINK_CLK_EN);
    chk("emph", 5, SER_EMPHASIS);
    rd(8'h04, d, r);
    chk("nodata", 4, d & 4);
    wr(8'h04, 32'h3f, r);
    rd(8'h04, d, r);
    chk("cleared", 0, d);
    $display("test enable done");
  endtask

  task t_sticky;
    NCO_UPSET <= 1'b1;
    wt(6);
    wr(8'h04, 32'h10, r);
    rd(8'h04, d, r);
    chk("set_wins", 32'h10, d);
    NCO_UPSET <= 1'b0;
    wt(4);
    wr(8'h04, 32'h0, r);
    rd(8'h04, d, r);
    chk("sticky", 32'h10, d);
    wr(8'h00, 32'h505, r);
    wt(3);
    rd(8'h0c, d, r);
    chk("summary", 1, d);
    @(negedge CLK);
    chk("pin_alarm", 1, CAL_STATUS_PIN);
    wr(8'h08, 32'h10, r);
    wt(3);
    rd(8'h0c, d, r);
    chk("masked", 0, d);
    @(negedge CLK);
    chk("pin_masked", 0, CAL_STATUS_PIN);
    wr(8'h08, 32'h0, r);
    wr(8'h04, 32'h10, r);
    rd(8'h04, d, r);
    chk("w1c", 0, d);
    $display("test sticky done");
  endtask

  task t_clk;
    wr(8'h00, 32'h504, r);
    wr(8'h00, 32'h505, r);
    wr(8'h04, 32'h20, r);
    CLK_PHASE_B <= 1'b1;
    wt(2);
    CLK_PHASE_B <= 1'b0;
    wt(6);
    rd(8'h04, d, r);
    chk("clk_upset", 32'h20, d & 32'h20);
    wt(20);
    rd(8'h04, d, r);
    chk("clk_hold", 32'h20, d & 32'h20);
    wr(8'h04, 32'h20, r);
    rd(8'h04, d, r);
    chk("clk_clr", 0, d & 32'h20);
    POWER_DOWN_PIN <= 1'b1;
    wt(4);
    POWER_DOWN_PIN <= 1'b0;
    wt(6);
    rd(8'h04, d, r);
    chk("pd_exit", 32'h20, d & 32'h20);
    wr(8'h04, 32'h3f, r);
    $display("test clock done");
  endtask

  task t_pll_sysref;
    SER_PLL_LOCK <= 1'b0;
    wt(2);
    SER_PLL_LOCK <= 1'b1;
    wt(6);
    rd(8'h04, d, r);
    chk("pll", 2, d & 2);
    wr(8'h00, 32'h525, r);
    SYSREF <= 1'b1;
    wt(4);
    SYSREF <= 1'b0;
    wr(8'h04, 32'h3f, r);
    // Second edge lands far from a multiframe boundary
    wt(40);
    SYSREF <= 1'b1;
    wt(6);
    SYSREF <= 1'b0;
    rd(8'h04, d, r);
    chk("realign", 8, d & 8);
    $display("test sysref done");
  endtask

  task t_fifo;
    int n;
    n = 0;
    LANE_FIFO_ERR <= 8'h08;
    wt(2);
    LANE_FIFO_ERR <= 8'h00;
    wt(6);
    rd(8'h04, d, r);
    chk("fifo", 1, d & 1);
    rd(8'h10, d, r);
    chk("lane", 8, d);
    wr(8'h10, 32'h8, r);
    rd(8'h10, d, r);
    chk("lane_clr", 0, d);
    wr(8'h00, 32'h527, r);
    LANE_FIFO_ERR <= 8'h01;
    wt(2);
    LANE_FIFO_ERR <= 8'h00;
    while (SER_REINIT !== 1'b1 && n < 12) begin
      @(negedge CLK);
      n++;
    end
    chk("reinit", 1, SER_REINIT);
    chk("reinit_off", 1, LINK_STATE);
    n = 0;
    while (SER_REINIT === 1'b1 && n < 40) begin
      @(negedge CLK);
      n++;
    end
    chk("reinit_len", 16, n);
    $display("test fifo done");
  endtask

  task t_code64;
    int n, p;
    n = 0;
    p = 0;
    wr(8'h00, 32'h0, r);
    wr(8'h00, 32'h58, r);
    chk("pda", 1, CH_A_POWER_DOWN);
    chk("pdb", 1, CH_B_POWER_DOWN);
    wr(8'h00, 32'h41, r);
    while (LINK_STATE !== 4'h8 && n < 200) begin
      @(negedge CLK);
      p = p + int'(LOCAL_EXTENDED_MULTIBLOCK_CLOCK === 1'b1);
      p = p - int'(LOCAL_MULTIFRAME_CLOCK === 1'b1);
      n++;
    end
    chk("state64", 8, LINK_STATE);
    chk("ext_mb_clk", 1, p > 0);
    n = 0;
    while (rel !== 1'b1 && n < 40) begin
      @(negedge CLK);
      n++;
    end
    chk("release", 1, rel);
    $display("test code64 done");
  endtask

  task t_disable;
    wr(8'h00, 32'h0, r);
    wt(2);
    @(negedge CLK);
    chk("dis_reset", 1, LINK_RESET);
    chk("dis_pd", 1, SER_POWER_DOWN);
    chk("dis_clk", 0, LINK_CLK_EN);
    chk("dis_state", 1, LINK_STATE);
    CAL_BUSY <= 1'b1;
    wt(4);
    @(negedge CLK);
    chk("cal_pin", 1, CAL_STATUS_PIN);
    $display("test disable done");
  endtask

  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
    {S_AXI_ARVALID, S_AXI_RREADY} = 2'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    S_AXI_WSTRB = 4'hf;
    LANE_FIFO_ERR = 8'h00;
    SER_PLL_LOCK = 1'b1;
    {SYSREF, NCO_UPSET, CLK_PHASE_A, CLK_PHASE_B} = 4'h0;
    {POWER_DOWN_PIN, CAL_BUSY} = 2'h0;
    {fail_count, tests_run, cyc} = 0;
    SYS_RST = 1'b1;
    wt(10);
    SYS_RST <= 1'b0;
    t_reset();
    t_enable();
    t_sticky();
    t_clk();
    t_pll_sysref();
    t_fifo();
    t_code64();
    t_disable();
    finish_test();
  end
endmodule
